// ### ssp_pkg.sv
// Constants shared by the serial port design files.
package ssp_pkg;
	localparam logic [7:0] SSP_OFF_CTRL = 8'h90;
	localparam logic [7:0] SSP_OFF_STAT = 8'h94;
	localparam logic [7:0] SSP_OFF_BUF = 8'h98;
	localparam logic [7:0] SSP_OFF_ADDR = 8'h9c;
	localparam logic [7:0] SSP_STAT_RST = 8'h00;
	localparam logic [7:0] SSP_CTRL_RST = 8'h00;
	localparam logic [7:0] SSP_ADDR_RST = 8'h00;
	localparam int ST_SMP = 7;
	localparam int ST_CKE = 6;
	localparam int CT_WCOL = 7;
	localparam int CT_OV = 6;
	localparam int CT_EN = 5;
	localparam int CT_CKP = 4;
	localparam logic [3:0] MODE_SLV_SS = 4'h4;
	localparam logic [3:0] MODE_SLV_NOSS = 4'h5;
	localparam logic [3:0] MODE_I2C7 = 4'h6;
	localparam logic [3:0] MODE_I2C10 = 4'h7;
	localparam logic [3:0] MODE_I2C_FW = 4'hb;
	localparam logic [3:0] MODE_I2C7_SP = 4'he;
	localparam logic [3:0] MODE_I2C10_SP = 4'hf;
	typedef enum logic [1:0] {SSP_DIV4, SSP_DIV16, SSP_DIV64, SSP_DIVTMR} ssp_rate_t;
	localparam logic [5:0] SSP_HALF_DIV4 = 6'h02;
	localparam logic [5:0] SSP_HALF_DIV16 = 6'h08;
	localparam logic [5:0] SSP_HALF_DIV64 = 6'h20;
	localparam logic [3:0] I2C_LAST_BIT = 4'h7;
	localparam logic [3:0] I2C_ACK_BIT = 4'h8;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	typedef enum {I2_IDLE, I2_ADDR, I2_ADDR2, I2_RX, I2_TX} ssp_i2c_t;
endpackage : ssp_pkg

// ### ssp_spi_eng.sv
// Shift engine for the four-wire mode, master timing and slave edges.
`timescale 1ns/10ps
module ssp_spi_eng
	import ssp_pkg::*;
#(
	parameter int W = 8
)(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_en,
	input wire logic i_master,
	input wire logic [1:0] i_rate,
	input wire logic i_tmr2_tick,
	input wire logic i_ckp,
	input wire logic i_cke,
	input wire logic i_smp,
	input wire logic i_ss_en,
	input wire logic i_ss_n,
	input wire logic i_sck,
	input wire logic i_sdi,
	input wire logic i_load,
	input wire logic [W-1:0] i_tx,
	output logic o_sck,
	output logic o_sdo,
	output logic o_busy,
	output logic o_done,
	output logic [W-1:0] o_rx
);
	localparam logic [5:0] EDGE_END = 6'(2 * W);
	localparam logic [3:0] LAST = 4'(W - 1);
	logic [5:0] half_q, half_lim, edge_q;
	logic run_q, prev_q, tick, mtick, m_tx, m_rx, s_tx, s_rx, act, lead, trail, done;
	logic [3:0] scnt_q;
	logic [W-1:0] sh_q, rx_q, rx_nx;

	always_comb
	begin
		unique case (ssp_rate_t'(i_rate))
			SSP_DIV4: half_lim = SSP_HALF_DIV4;
			SSP_DIV16: half_lim = SSP_HALF_DIV16;
			SSP_DIV64: half_lim = SSP_HALF_DIV64;
			SSP_DIVTMR: half_lim = SSP_HALF_DIV4;
		endcase
	end
	// The timer rate toggles once per timer tick, so the clock is half the tick rate.
	assign tick = (ssp_rate_t'(i_rate) == SSP_DIVTMR) ? i_tmr2_tick : (half_q == half_lim - 6'h01);
	assign mtick = run_q & tick;
	// Leading edges are even edge numbers; the end slot has no toggle.
	assign m_tx = mtick & (i_cke ? (~edge_q[0] & edge_q != 6'h00 & edge_q < EDGE_END) : edge_q[0]); // see (R08)
	assign m_rx = mtick & (i_smp ? (i_cke ? (~edge_q[0] & edge_q != 6'h00) : edge_q[0])
		: (i_cke ? edge_q[0] : (~edge_q[0] & edge_q < EDGE_END))); // see (R06)
	assign act = i_en & ~i_master & ~(i_ss_en & i_ss_n); // see (R04)
	assign lead = i_ckp ? (prev_q & ~i_sck) : (~prev_q & i_sck);
	assign trail = i_ckp ? (~prev_q & i_sck) : (prev_q & ~i_sck);
	// Slave sampling is always mid-bit; software keeps the sample-phase bit clear there.
	assign s_tx = act & (i_cke ? (lead & scnt_q != 4'h0) : trail); // see (R08) (R07)
	assign s_rx = act & (i_cke ? trail : lead);
	assign rx_nx = (m_rx | s_rx) ? {rx_q[W-2:0], i_sdi} : rx_q; // see (R21)
	assign done = (mtick & edge_q == EDGE_END) | (s_rx & scnt_q == LAST); // see (R02)
	assign o_busy = run_q | scnt_q != 4'h0;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst | ~i_en | ~i_master)
		begin
			run_q <= 1'b0;
			half_q <= 6'h00;
			edge_q <= 6'h00;
		end
		else if (i_load & ~run_q)
		begin
			run_q <= 1'b1;
			half_q <= 6'h00;
			edge_q <= 6'h00;
		end
		else if (mtick)
		begin
			half_q <= 6'h00;
			edge_q <= edge_q + 6'h01;
			run_q <= edge_q != EDGE_END;
		end
		else if (run_q)
			half_q <= half_q + 6'h01;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			o_sck <= 1'b0;
		else if (~run_q)
			o_sck <= i_ckp; // see (R18)
		else if (mtick & edge_q < EDGE_END)
			o_sck <= ~o_sck; // see (R03)
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst | ~act)
			scnt_q <= 4'h0;
		else if (s_rx)
			scnt_q <= (scnt_q == LAST) ? 4'h0 : scnt_q + 4'h1;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			prev_q <= 1'b0;
			sh_q <= '0;
			rx_q <= '0;
			o_done <= 1'b0;
			o_rx <= '0;
		end
		else
		begin
			prev_q <= i_sck;
			rx_q <= rx_nx;
			o_done <= done;
			if (done)
				o_rx <= rx_nx;
			if (i_load & ~o_busy)
				sh_q <= i_tx;
			else if (m_tx | s_tx)
				sh_q <= {sh_q[W-2:0], 1'b0}; // see (R21)
		end
	end
	assign o_sdo = sh_q[W-1];

	chk_sck_idle: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		$fell(run_q) |=> o_sck == i_ckp) else $error("clock not idle after frame"); // see (R18)
	chk_ss_release: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_en & ~i_master & i_ss_en & i_ss_n |=> scnt_q == 4'h0) else $error("select ignored"); // see (R04)
	chk_msb_first: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_load & ~o_busy |=> o_sdo == $past(i_tx[W-1])) else $error("msb not first"); // see (R21)
	chk_done_pulse: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_done |=> ~o_done) else $error("done held"); // see (R02)
endmodule : ssp_spi_eng

// ### ssp_port.sv
// Serial port top: register slave, status register and two-wire slave.
// Functional notes
// (R01) One protocol at a time, chosen by mode.
// (R02) Eight bits shifted out and in together.
// (R03) Master drives clock; slave takes clock in.
// (R04) Optional slave-select input gates slave transfers.
// (R05) Options from control low bits, status high.
// (R06) Sample phase: end or middle of bit.
// (R07) Software keeps sample phase clear as slave.
// (R08) Clock edge bit picks the transmit edge.
// (R09) Software clears phase and edge in two-wire.
// (R10) Data/address bit tracks last byte kind.
// (R11) Stop flag: set on stop, cleared otherwise.
// (R12) Start flag: set on start, cleared otherwise.
// (R13) Direction bit captures matched address read/write.
// (R14) Update-address flag asks for address reload.
// (R15) Buffer full once received word is held.
// (R16) Two-wire transmit: full until byte sent.
// (R17) Status: top two bits writable, reset zero.
// (R18) Clock polarity sets clock idle level.
// (R19) Mode field picks rate or slave kind.
// (R20) Slave overflow flags and drops new byte.
// (R21) Words shift most-significant bit first.
// (R22) Reading the buffer clears buffer full.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module ssp_port
	import ssp_pkg::*;
#(
	parameter int W = 8
)(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	output logic [1:0] o_s_axi_bresp,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	input wire logic [7:0] i_s_axi_araddr,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	input wire logic i_tmr2_tick,
	input wire logic i_sck,
	output logic o_sck,
	output logic o_sck_oe,
	input wire logic i_sdi,
	output logic o_sdo,
	output logic o_sdo_oe,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic i_ss_n
);
	logic [7:0] ctrl_q, addr_q, buf_q, aw_q, wd_q;
	logic smp_q, cke_q, da_q, p_q, s_q, rw_q, ua_q, bf_q, ws_q;
	logic en, is_master, is_slave, is_i2c, i2c_slv, ten, busy, sdone;
	logic wr_fire, rd_fire, wbuf, rbuf, wcol, ov, mapped_w, mapped_r;
	logic [7:0] rx, stat, byte_in;
	logic scl_q, sda_q, start, stop, rise, fall, bdone;
	logic hit1, hit2, rxdat, store, txdone, ack_q;
	logic [3:0] icnt_q;
	logic [7:0] ish_q, tsh_q;
	ssp_i2c_t ph_q;

	assign en = ctrl_q[CT_EN];
	// Mode codes split the port into at most one active protocol; unused codes enable none.
	assign is_master = en & ctrl_q[3:2] == 2'b00; // see (R01) (R19)
	assign is_slave = en & (ctrl_q[3:0] == MODE_SLV_SS | ctrl_q[3:0] == MODE_SLV_NOSS); // see (R19)
	assign is_i2c = en & (ctrl_q[3:0] == MODE_I2C7 | ctrl_q[3:0] == MODE_I2C10
		| ctrl_q[3:0] == MODE_I2C_FW | ctrl_q[3:0] == MODE_I2C7_SP
		| ctrl_q[3:0] == MODE_I2C10_SP); // see (R01)
	assign i2c_slv = is_i2c & ctrl_q[3:0] != MODE_I2C_FW;
	assign ten = ctrl_q[3:0] == MODE_I2C10 | ctrl_q[3:0] == MODE_I2C10_SP;
	assign stat = {smp_q, cke_q, da_q, p_q, s_q, rw_q, ua_q, bf_q};

	ssp_spi_eng #(.W(W)) u_eng (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_en(is_master | is_slave),
		.i_master(is_master),
		.i_rate(ctrl_q[1:0]), // see (R05)
		.i_tmr2_tick(i_tmr2_tick),
		.i_ckp(ctrl_q[CT_CKP]),
		.i_cke(cke_q),
		.i_smp(smp_q),
		.i_ss_en(ctrl_q[3:0] == MODE_SLV_SS), // see (R05)
		.i_ss_n(i_ss_n),
		.i_sck(i_sck),
		.i_sdi(i_sdi),
		.i_load(wbuf & (is_master | is_slave)),
		.i_tx(wd_q),
		.o_sck(o_sck),
		.o_sdo(o_sdo),
		.o_busy(busy),
		.o_done(sdone),
		.o_rx(rx)
	);

	// Write address and data are caught separately, so either may arrive first.
	assign wr_fire = ~o_s_axi_awready & ~o_s_axi_wready & ~o_s_axi_bvalid;
	assign rd_fire = i_s_axi_arvalid & o_s_axi_arready;
	assign mapped_w = aw_q == SSP_OFF_CTRL | aw_q == SSP_OFF_STAT
		| aw_q == SSP_OFF_BUF | aw_q == SSP_OFF_ADDR;
	assign mapped_r = i_s_axi_araddr == SSP_OFF_CTRL | i_s_axi_araddr == SSP_OFF_STAT
		| i_s_axi_araddr == SSP_OFF_BUF | i_s_axi_araddr == SSP_OFF_ADDR;
	assign wbuf = wr_fire & ws_q & aw_q == SSP_OFF_BUF;
	assign rbuf = rd_fire & i_s_axi_araddr == SSP_OFF_BUF;
	assign wcol = wbuf & (busy | (ph_q == I2_TX & icnt_q != 4'h0));
	assign ov = (sdone & is_slave & bf_q & ~rbuf) | (rxdat & bf_q); // see (R20)

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			o_s_axi_awready <= 1'b1;
			o_s_axi_wready <= 1'b1;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= AXI_OKAY;
			aw_q <= 8'h00;
			wd_q <= 8'h00;
			ws_q <= 1'b0;
		end
		else
		begin
			if (i_s_axi_awvalid & o_s_axi_awready)
			begin
				aw_q <= i_s_axi_awaddr;
				o_s_axi_awready <= 1'b0;
			end
			if (i_s_axi_wvalid & o_s_axi_wready)
			begin
				wd_q <= i_s_axi_wdata[7:0];
				ws_q <= i_s_axi_wstrb[0];
				o_s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp <= mapped_w ? AXI_OKAY : AXI_SLVERR;
			end
			if (o_s_axi_bvalid & i_s_axi_bready)
			begin
				o_s_axi_bvalid <= 1'b0;
				o_s_axi_awready <= 1'b1;
				o_s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			o_s_axi_arready <= 1'b1;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0000_0000;
			o_s_axi_rresp <= AXI_OKAY;
		end
		else if (rd_fire)
		begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rresp <= mapped_r ? AXI_OKAY : AXI_SLVERR;
			unique case (i_s_axi_araddr)
				SSP_OFF_CTRL: o_s_axi_rdata <= {24'h00_0000, ctrl_q};
				SSP_OFF_STAT: o_s_axi_rdata <= {24'h00_0000, stat};
				SSP_OFF_BUF: o_s_axi_rdata <= {24'h00_0000, buf_q};
				SSP_OFF_ADDR: o_s_axi_rdata <= {24'h00_0000, addr_q};
				default: o_s_axi_rdata <= 32'h0000_0000;
			endcase
		end
		else if (o_s_axi_rvalid & i_s_axi_rready)
		begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_arready <= 1'b1;
		end
	end

	// Hardware-set flags win over a software write in the same cycle.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			ctrl_q <= SSP_CTRL_RST;
			addr_q <= SSP_ADDR_RST;
			smp_q <= SSP_STAT_RST[ST_SMP];
			cke_q <= SSP_STAT_RST[ST_CKE];
		end
		else
		begin
			if (wr_fire & ws_q & aw_q == SSP_OFF_CTRL)
				ctrl_q <= wd_q;
			if (wr_fire & ws_q & aw_q == SSP_OFF_STAT)
			begin
				smp_q <= wd_q[ST_SMP]; // see (R17)
				cke_q <= wd_q[ST_CKE]; // see (R17)
			end
			if (wr_fire & ws_q & aw_q == SSP_OFF_ADDR)
				addr_q <= wd_q;
			if (wcol)
				ctrl_q[CT_WCOL] <= 1'b1;
			if (ov)
				ctrl_q[CT_OV] <= 1'b1; // see (R20)
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			buf_q <= 8'h00;
			bf_q <= 1'b0;
		end
		else if (sdone & ~(is_slave & bf_q & ~rbuf))
		begin
			buf_q <= rx; // see (R15)
			bf_q <= 1'b1;
		end
		else if (store)
		begin
			buf_q <= byte_in; // see (R15)
			bf_q <= 1'b1;
		end
		else if (wbuf & is_i2c & ~wcol)
		begin
			buf_q <= wd_q;
			bf_q <= 1'b1; // see (R16)
		end
		else if (rbuf | txdone)
			bf_q <= 1'b0; // see (R22) (R16)
	end

	// Start and stop are data edges while the clock stays high.
	assign start = is_i2c & scl_q & i_sck & sda_q & ~i_sdi;
	assign stop = is_i2c & scl_q & i_sck & ~sda_q & i_sdi;
	assign rise = ~scl_q & i_sck;
	assign fall = scl_q & ~i_sck;
	assign bdone = rise & icnt_q == I2C_LAST_BIT & ph_q != I2_IDLE;
	assign byte_in = {ish_q[6:0], i_sdi};
	assign hit1 = bdone & ph_q == I2_ADDR & byte_in[7:1] == addr_q[7:1];
	assign hit2 = bdone & ph_q == I2_ADDR2 & byte_in == addr_q;
	assign rxdat = bdone & ph_q == I2_RX;
	assign store = (hit1 | hit2 | rxdat) & ~bf_q;
	assign txdone = bdone & ph_q == I2_TX;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst | ~i2c_slv)
		begin
			ph_q <= I2_IDLE;
			icnt_q <= 4'h0;
			ack_q <= 1'b0;
		end
		else if (start)
		begin
			ph_q <= I2_ADDR;
			icnt_q <= 4'h0;
		end
		else if (stop)
			ph_q <= I2_IDLE;
		else if (rise & ph_q != I2_IDLE)
		begin
			icnt_q <= (icnt_q == I2C_ACK_BIT) ? 4'h0 : icnt_q + 4'h1;
			if (icnt_q == I2C_ACK_BIT & ph_q == I2_TX & i_sdi)
				ph_q <= I2_IDLE;
			if (bdone)
			begin
				ack_q <= store;
				if (ph_q == I2_ADDR)
					ph_q <= ~hit1 ? I2_IDLE : byte_in[0] ? I2_TX : ten ? I2_ADDR2 : I2_RX;
				else if (ph_q == I2_ADDR2)
					ph_q <= hit2 ? I2_RX : I2_IDLE;
			end
		end
	end

	// Open-drain data: the enable pulls low, the driven level is always low.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			ish_q <= 8'h00;
			tsh_q <= 8'h00;
			o_sda <= 1'b0;
			o_sda_oe <= 1'b0;
		end
		else
		begin
			scl_q <= i_sck;
			sda_q <= i_sdi;
			if (rise & icnt_q < I2C_ACK_BIT)
				ish_q <= byte_in;
			if (~i2c_slv | start | stop)
				o_sda_oe <= 1'b0;
			else if (fall & icnt_q == I2C_ACK_BIT)
				o_sda_oe <= ack_q;
			else if (fall & icnt_q == 4'h0 & ph_q == I2_TX)
			begin
				o_sda_oe <= ~buf_q[7]; // see (R21)
				tsh_q <= {buf_q[6:0], 1'b0};
			end
			else if (fall & ph_q == I2_TX)
			begin
				o_sda_oe <= ~tsh_q[7];
				tsh_q <= {tsh_q[6:0], 1'b0};
			end
			else if (fall)
				o_sda_oe <= 1'b0;
		end
	end

	// Software keeps phase and edge clear in two-wire mode, so no gating is needed here.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst | ~en)
		begin
			p_q <= 1'b0; // see (R11)
			s_q <= 1'b0; // see (R12)
			da_q <= 1'b0;
			rw_q <= 1'b0;
			ua_q <= 1'b0;
		end
		else
		begin
			if (start)
			begin
				s_q <= 1'b1; // see (R12)
				p_q <= 1'b0; // see (R11)
			end
			else if (stop)
			begin
				p_q <= 1'b1; // see (R11)
				s_q <= 1'b0; // see (R12)
			end
			if (hit1 | hit2)
				da_q <= 1'b0; // see (R10)
			else if (rxdat | txdone)
				da_q <= 1'b1; // see (R10)
			if (hit1)
				rw_q <= byte_in[0]; // see (R13)
			if (ten & (hit1 | hit2))
				ua_q <= 1'b1; // see (R14)
			else if (wr_fire & ws_q & aw_q == SSP_OFF_ADDR)
				ua_q <= 1'b0; // see (R14)
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			o_sck_oe <= 1'b0;
			o_sdo_oe <= 1'b0;
		end
		else
		begin
			o_sck_oe <= is_master | (is_i2c & ~ctrl_q[CT_CKP]); // see (R03)
			o_sdo_oe <= is_master | (is_slave & ~(ctrl_q[3:0] == MODE_SLV_SS & i_ss_n));
		end
	end

	chk_start_flag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		start & en |=> s_q & ~p_q) else $error("start flag wrong"); // see (R12)
	chk_stop_flag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		stop & en |=> p_q & ~s_q) else $error("stop flag wrong"); // see (R11)
	chk_disable_clr: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		~en ##1 ~en |-> ~s_q & ~p_q) else $error("flags kept while off"); // see (R11) (R12)
	chk_ov_drop: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		sdone & is_slave & bf_q & ~rbuf |=> ctrl_q[CT_OV] & $stable(buf_q))
		else $error("overflow missed"); // see (R20)
	chk_bf_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		rbuf & ~sdone & ~store & ~(wbuf & is_i2c) |=> ~bf_q) else $error("read kept full"); // see (R22)
	chk_rx_full: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		store |=> bf_q & buf_q == $past(byte_in)) else $error("receive not held"); // see (R15)
	chk_rw_capture: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		hit1 |=> rw_q == $past(i_sdi) & ~da_q) else $error("direction not caught"); // see (R13)
endmodule : ssp_port

// ### ssp_far_dev.sv
// Far-side serial device model: answers a master, or acts as master itself.
`timescale 1ns/10ps
module ssp_far_dev (
	input wire logic i_ref_clk,
	input wire logic i_arm,
	input wire logic i_as_master,
	input wire logic i_tx_rise,
	input wire logic [7:0] i_tx,
	input wire logic i_sck,
	input wire logic i_sdo,
	output logic o_sck,
	output logic o_sdi,
	output logic o_done,
	output logic [7:0] o_rx
);
	logic arm_q;
	logic sck_q;
	logic sck_eff;
	logic [3:0] nsamp;
	logic [4:0] nedge;
	logic [2:0] div;
	assign sck_eff = i_as_master ? o_sck : i_sck;
	initial
	begin
		o_sck = 1'b0;
		o_sdi = 1'b0;
		o_done = 1'b0;
		o_rx = 8'h00;
		arm_q = 1'b0;
		sck_q = 1'b0;
		nsamp = 4'h0;
		nedge = 5'h00;
		div = 3'h0;
	end
	always @(posedge i_ref_clk)
	begin
		arm_q <= i_arm;
		sck_q <= sck_eff;
		if (i_arm && !arm_q)
		begin
			nsamp <= 4'h0;
			nedge <= 5'h00;
			div <= 3'h0;
			o_sdi <= i_tx[7];
		end
		else if (!i_arm)
		begin
			// A released line must not look like held data.
			o_sdi <= ~o_sdi;
			o_done <= 1'b0;
		end
		else
		begin
			if (i_as_master && nedge < 5'd16)
			begin
				div <= div + 3'h1;
				if (div == 3'h7)
				begin
					o_sck <= ~o_sck;
					nedge <= nedge + 5'h01;
				end
			end
			if (i_as_master && nedge == 5'd16)
				o_done <= 1'b1;
			if (sck_eff != sck_q)
			begin
				if (sck_eff == i_tx_rise)
				begin
					if (nsamp != 4'h0 && nsamp < 4'h8)
						o_sdi <= i_tx[3'h7 - nsamp[2:0]];
				end
				else
				begin
					o_rx <= {o_rx[6:0], i_sdo};
					nsamp <= nsamp + 4'h1;
				end
			end
		end
	end
endmodule : ssp_far_dev

// ### tb_top.sv
// Testbench for the serial port: register access, four-wire and two-wire transfers.
`timescale 1ns/10ps
module tb_top;
	import ssp_pkg::*;
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready, tick, ss_n, arm, as_mst;
	logic tx_rise, awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, sdo, sdo_oe;
	logic fsck, fsdi, fdone, sck_q, clock_polarity, cke, sample_phase;
	logic i2c_on, scl, sda, sda_oe;
	logic [7:0] ib;
	logic [7:0] awaddr, araddr, ftx, frx, rv;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp, tk;
	logic [5:0] gap, last_gap;
	logic [5:0] half [4];
	int n_fail, num_checks, cyc;
	ssp_port i_ssp_port (.i_ref_clk(clk), .i_sys_rst(rst), .i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
		.o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
		.i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .i_s_axi_araddr(araddr),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_s_axi_rdata(rdata),
		.o_s_axi_rresp(rresp), .i_tmr2_tick(tick), .i_sck(i2c_on ? scl : fsck),
		.o_sck(sck_o), .o_sck_oe(sck_oe), .i_sdi(i2c_on ? (sda & ~sda_oe) : fsdi),
		.o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_sda(), .o_sda_oe(sda_oe), .i_ss_n(ss_n));
	ssp_far_dev i_ssp_far_dev (.i_ref_clk(clk), .i_arm(arm), .i_as_master(as_mst),
		.i_tx_rise(tx_rise), .i_tx(ftx), .i_sck(sck_o), .i_sdo(sdo), .o_sck(fsck),
		.o_sdi(fsdi), .o_done(fdone), .o_rx(frx));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task axi_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= {24'h000000, d};
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		rsp = bresp;
	endtask : axi_wr
	task axi_rd(input logic [7:0] a);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		rv = rdata[7:0];
		rsp = rresp;
	endtask : axi_rd
	task wait_full;
		do
			axi_rd(SSP_OFF_STAT);
		while (rv[0] !== 1'b1);
	endtask : wait_full
	task far_frame(input logic [7:0] d);
		ftx <= d;
		arm <= 1'b1;
		repeat (2) @(posedge clk);
		while (fdone !== 1'b1)
			@(posedge clk);
		repeat (4) @(posedge clk);
		arm <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : far_frame
	task i2c_bit(input logic b);
		sda <= b;
		repeat (4) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		scl <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : i2c_bit
	always @(posedge clk)
	begin
		cyc++;
		tk <= tk + 2'h1;
		tick <= (tk == 2'h3);
		sck_q <= sck_o;
		if (sck_o !== sck_q)
		begin
			last_gap <= gap;
			gap <= 6'h01;
		end
		else
			gap <= gap + 6'h01;
		if (cyc == 40000)
		begin
			n_fail++;
			give_verdict;
		end
	end
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, tick, arm, as_mst, tx_rise} = 9'h000;
		{awaddr, araddr, ftx, wdata, tk, gap, last_gap, sck_q} = '0;
		wstrb = 4'hf;
		ss_n = 1'b1;
		i2c_on = 1'b0;
		scl = 1'b1;
		sda = 1'b1;
		ib = 8'ha4;
		rst = 1'b1;
		half = '{SSP_HALF_DIV4, SSP_HALF_DIV16, SSP_HALF_DIV64, 6'h04};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		axi_rd(SSP_OFF_STAT);
		chk(rv, SSP_STAT_RST);
		axi_wr(SSP_OFF_STAT, 8'hff);
		axi_rd(SSP_OFF_STAT);
		chk(rv, 8'hc0);
		axi_rd(8'ha0);
		chk({6'h00, rsp}, {6'h00, AXI_SLVERR});
		axi_wr(8'ha0, 8'h55);
		chk({6'h00, rsp}, {6'h00, AXI_SLVERR});
		$display("register test done");
		for (int i = 0; i < 4; i++)
		begin
			clock_polarity = i[0];
			cke = i[1];
			sample_phase = i[0] ^ i[1];
			axi_wr(SSP_OFF_CTRL, 8'h00);
			axi_wr(SSP_OFF_STAT, {sample_phase, cke, 6'h00});
			axi_wr(SSP_OFF_CTRL, {3'b001, clock_polarity, 2'b00, i[1:0]});
			tx_rise <= clock_polarity ^ cke;
			ftx <= 8'h3c + i[7:0];
			arm <= 1'b1;
			repeat (3) @(posedge clk);
			chk({7'h00, sck_o}, {7'h00, clock_polarity});
			chk({7'h00, sck_oe}, 8'h01);
			axi_wr(SSP_OFF_BUF, 8'ha5 ^ i[7:0]);
			wait_full;
			chk(rv, {sample_phase, cke, 6'h01});
			chk({2'b00, last_gap}, {2'b00, half[i]});
			axi_rd(SSP_OFF_BUF);
			chk(rv, 8'h3c + i[7:0]);
			chk(frx, 8'ha5 ^ i[7:0]);
			axi_rd(SSP_OFF_STAT);
			chk(rv, {sample_phase, cke, 6'h00});
			arm <= 1'b0;
		end
		$display("master test done");
		axi_wr(SSP_OFF_CTRL, 8'h00);
		axi_wr(SSP_OFF_STAT, 8'h00);
		axi_wr(SSP_OFF_CTRL, 8'h25);
		repeat (2) @(posedge clk);
		chk({7'h00, sck_oe}, 8'h00);
		axi_wr(SSP_OFF_BUF, 8'h5a);
		as_mst <= 1'b1;
		tx_rise <= 1'b0;
		far_frame(8'h96);
		wait_full;
		chk(rv, 8'h01);
		chk(frx, 8'h5a);
		far_frame(8'h11);
		axi_rd(SSP_OFF_CTRL);
		chk(rv, 8'h65);
		axi_rd(SSP_OFF_BUF);
		chk(rv, 8'h96);
		$display("slave test done");
		as_mst <= 1'b0;
		axi_wr(SSP_OFF_CTRL, 8'h00);
		axi_wr(SSP_OFF_CTRL, 8'h24);
		repeat (3) @(posedge clk);
		chk({7'h00, sdo_oe}, 8'h00);
		ss_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk({7'h00, sdo_oe}, 8'h01);
		$display("select test done");
		axi_wr(SSP_OFF_CTRL, 8'h00);
		i2c_on <= 1'b1;
		axi_wr(SSP_OFF_ADDR, ib);
		axi_wr(SSP_OFF_CTRL, 8'h36);
		repeat (4) @(posedge clk);
		sda <= 1'b0;
		repeat (4) @(posedge clk);
		scl <= 1'b0;
		repeat (4) @(posedge clk);
		for (int j = 7; j >= 0; j--)
			i2c_bit(ib[j]);
		sda <= 1'b1;
		repeat (4) @(posedge clk);
		chk({7'h00, sda_oe}, 8'h01);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		scl <= 1'b0;
		repeat (4) @(posedge clk);
		axi_rd(SSP_OFF_STAT);
		chk(rv, 8'h09);
		sda <= 1'b0;
		repeat (4) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		sda <= 1'b1;
		repeat (4) @(posedge clk);
		axi_rd(SSP_OFF_STAT);
		chk(rv, 8'h11);
		axi_rd(SSP_OFF_BUF);
		chk(rv, ib);
		axi_rd(SSP_OFF_STAT);
		chk(rv, 8'h10);
		$display("two-wire test done");
		give_verdict;
	end
endmodule : tb_top
